// File: rtl/abt_ctrl.sv
// converter control: registers, boost reference sequencing, triggers, channels
// assumes a CPU-side register port with per-bit write mask; wait_o asks the master for one stall cycle
`timescale 1ns/10ps
`default_nettype none
module abt_ctrl #(
  parameter int MAIN_CLK_DIV = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire abt_pkg::abt_bus_req_s bus_req_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_wait_o,
  input wire logic ext_trig_pin_i,
  input wire logic timer_trig_event_i,
  output logic boost_gen_on_o,
  output logic ref_settled_o,
  output logic conv_busy_o,
  output logic conv_start_o,
  output logic conv_done_irq_o,
  output logic [1:0] analog_sel_o,
  output logic [7:0] conv_cycles_o,
  output logic cfg_ok_o
);
  import abt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  abt_mode_s mode;
  abt_chan_s chan;
  abt_mode_s next_mode;
  abt_chan_s next_chan;
  logic mode_wr;
  logic chan_wr;
  logic any_wr;

  always_comb begin
    mode_wr = bus_req_i.wr && (bus_req_i.addr == ABT_ADDR_MODE);
    chan_wr = bus_req_i.wr && (bus_req_i.addr == ABT_ADDR_CHAN);
    any_wr = mode_wr || chan_wr || (bus_req_i.wr && ((bus_req_i.addr == ABT_ADDR_PFAIL_MODE) ||
             (bus_req_i.addr == ABT_ADDR_PFAIL_THR)));
    next_mode = mode;
    next_chan = chan;
    if (mode_wr) begin
      next_mode = (mode & ~bus_req_i.wmask) | (bus_req_i.wdata & bus_req_i.wmask);
    end
    if (chan_wr) begin
      next_chan = ((chan & ~bus_req_i.wmask) | (bus_req_i.wdata & bus_req_i.wmask)) & ABT_CHAN_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= ABT_MODE_RESET;
      chan <= ABT_CHAN_RESET;
    end else begin
      mode <= next_mode;
      chan <= next_chan;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_req_i.rd) begin
      if (bus_req_i.addr == ABT_ADDR_MODE) begin
        bus_rdata_o <= mode;
      end else if (bus_req_i.addr == ABT_ADDR_CHAN) begin
        bus_rdata_o <= chan;
      end else begin
        bus_rdata_o <= 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_wait_o <= 1'b0;
    end else begin
      bus_wait_o <= mode_wr || chan_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost reference generator and settling

  logic [6:0] settle_cnt;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_gen_on_o <= 1'b0;
    end else begin
      boost_gen_on_o <= next_mode.boost_ref_enable | next_mode.conv_enable;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_cnt <= 7'h00;
    end else if (!boost_gen_on_o) begin
      settle_cnt <= 7'h00;
    end else if (settle_cnt != 7'(ABT_SETTLE_CYC)) begin
      settle_cnt <= settle_cnt + 7'h01;
    end
  end

  assign ref_settled_o = (settle_cnt == 7'(ABT_SETTLE_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // conversion time decode

  function automatic logic [7:0] cyc_decode(input logic [1:0] speed, input logic [2:0] tsel);
    logic [7:0] r;
    r = 8'h00;
    if (speed == ABT_SPEED_STD) begin
      r = ABT_CYC_STD[tsel];
    end else if (speed == ABT_SPEED_FAST && !tsel[2]) begin
      r = ABT_CYC_FAST[tsel[1:0]];
    end
    return r;
  endfunction : cyc_decode

  logic [7:0] next_cycles;
  logic next_cfg_ok;

  always_comb begin
    next_cycles = cyc_decode(next_mode.conv_speed_sel, next_mode.conv_time_sel);
    next_cfg_ok = (next_cycles != 8'h00) && !next_chan.chan_sel[2];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cycles_o <= 8'h00;
      cfg_ok_o <= 1'b0;
    end else begin
      conv_cycles_o <= next_cycles;
      cfg_ok_o <= next_cfg_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger sources

  logic main_clk_tick;
  logic ext_hit;

  abt_tick_div #(.DIV(MAIN_CLK_DIV)) u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_o(main_clk_tick)
  );

  abt_edge_det u_edge (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_trig_pin_i),
    .enable_i(chan.trig_source_sel && !chan.hw_trig_type),
    .edge_sel_i(chan.trig_edge_sel),
    .hit_o(ext_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  abt_state_e state;
  abt_state_e next_state;
  logic start;
  logic done;
  logic fresh;
  logic restart_pend;
  logic trig_hit;
  logic [7:0] cnt;

  always_comb begin
    trig_hit = next_chan.trig_source_sel &&
               (next_chan.hw_trig_type ? timer_trig_event_i : ext_hit);
    fresh = restart_pend;
    start = 1'b0;
    done = 1'b0;
    next_state = state;
    if (!next_mode.conv_enable || !next_cfg_ok) begin
      next_state = ABT_ST_IDLE;
    end else if (any_wr || state == ABT_ST_IDLE) begin
      fresh = 1'b1;
      next_state = next_chan.trig_source_sel ? ABT_ST_WAIT : ABT_ST_CONV;
      start = !next_chan.trig_source_sel;
    end else begin
      case (state)
        ABT_ST_WAIT: begin
          if (trig_hit) begin
            next_state = ABT_ST_CONV;
            start = 1'b1;
          end
        end
        ABT_ST_CONV: begin
          if (main_clk_tick && cnt == 8'h01) begin
            done = 1'b1;
            next_state = next_chan.trig_source_sel ? ABT_ST_WAIT : ABT_ST_CONV;
            start = !next_chan.trig_source_sel;
          end
        end
        default: begin
          next_state = ABT_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ABT_ST_IDLE;
      conv_start_o <= 1'b0;
      conv_done_irq_o <= 1'b0;
    end else begin
      state <= next_state;
      conv_start_o <= start;
      conv_done_irq_o <= done;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else if (start) begin
      cnt <= next_cycles;
    end else if (state == ABT_ST_CONV && main_clk_tick && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      restart_pend <= 1'b0;
      analog_sel_o <= 2'h0;
    end else begin
      restart_pend <= fresh && !start;
      if (start) begin
        if (!next_mode.scan_select) begin
          analog_sel_o <= next_chan.chan_sel[1:0];
        end else if (fresh || analog_sel_o == next_chan.chan_sel[1:0]) begin
          analog_sel_o <= 2'h0;
        end else begin
          analog_sel_o <= analog_sel_o + 2'h1;
        end
      end
    end
  end

  assign conv_busy_o = (state == ABT_ST_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  boost_auto_on_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(mode.conv_enable) |-> boost_gen_on_o) else $error("generator not on with enable");
  boost_auto_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(mode.conv_enable) && !mode.boost_ref_enable |-> !boost_gen_on_o)
    else $error("generator left on after enable cleared");
  boost_stays_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(mode.conv_enable) && mode.boost_ref_enable |-> boost_gen_on_o)
    else $error("generator dropped while boost set");
  settle_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(ref_settled_o) |-> $past(boost_gen_on_o, ABT_SETTLE_CYC) && boost_gen_on_o)
    else $error("reference settled too early");
  stop_idle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !mode.conv_enable |-> state == ABT_ST_IDLE && !conv_start_o) else $error("activity while disabled");
  time_decode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mode.conv_speed_sel == 2'b01 && mode.conv_time_sel == 3'b100 |-> conv_cycles_o == 8'hE0)
    else $error("wrong conversion length");
  fast_forbid_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mode.conv_speed_sel == 2'b10 && mode.conv_time_sel[2] |-> !cfg_ok_o) else $error("prohibited time accepted");
  sw_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(mode.conv_enable) && !chan.trig_source_sel && cfg_ok_o |-> conv_start_o)
    else $error("software start missing");
  hw_wait_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state == ABT_ST_WAIT |-> chan.trig_source_sel) else $error("waiting in software mode");
  trig_cause_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_start_o && $past(state == ABT_ST_WAIT) && !$past(any_wr) |->
    $past(chan.hw_trig_type ? timer_trig_event_i : ext_hit)) else $error("start without trigger");
  repeat_conv_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_done_irq_o && !chan.trig_source_sel |-> conv_start_o) else $error("no back to back restart");
  abort_conv_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    any_wr && state == ABT_ST_CONV |=> !conv_done_irq_o) else $error("conversion not aborted");
  wait_cycle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mode_wr || chan_wr |=> bus_wait_o) else $error("no wait cycle after write");
  select_chan_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_start_o && !mode.scan_select |-> analog_sel_o == chan.chan_sel[1:0])
    else $error("wrong channel in select mode");
  scan_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_start_o && mode.scan_select |-> analog_sel_o <= chan.chan_sel[1:0])
    else $error("scan channel beyond range");
  ext_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !chan.trig_source_sel || chan.hw_trig_type |-> !ext_hit) else $error("pin edge not gated");
  settle_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !boost_gen_on_o |=> !ref_settled_o) else $error("settled while generator off");
  stop_power_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !mode.conv_enable && !mode.boost_ref_enable |-> !boost_gen_on_o) else $error("generator on while stopped");
  abort_restart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    any_wr && state == ABT_ST_CONV && next_mode.conv_enable && next_cfg_ok && !next_chan.trig_source_sel |=>
    conv_start_o && conv_busy_o) else $error("no restart after abort");
endmodule : abt_ctrl
`default_nettype wire

// File: common/abt_pkg.sv
// constants, register layouts and state codes for the converter control block
// assumes one 50 MHz system clock and an 8-bit memory-mapped register port
package abt_pkg;
  localparam logic [15:0] ABT_ADDR_MODE = 16'hFF6C;
  localparam logic [15:0] ABT_ADDR_CHAN = 16'hFF6D;
  localparam logic [15:0] ABT_ADDR_PFAIL_MODE = 16'hFF6E;
  localparam logic [15:0] ABT_ADDR_PFAIL_THR = 16'hFF6F;
  localparam logic [7:0] ABT_MODE_RESET = 8'h00;
  localparam logic [7:0] ABT_CHAN_RESET = 8'h00;
  localparam logic [7:0] ABT_CHAN_WR_MASK = 8'hF7;
  localparam int ABT_CLK_NS = 20;
  localparam int ABT_SETTLE_NS = 1000;
  localparam int ABT_SETTLE_CYC = (ABT_SETTLE_NS + ABT_CLK_NS - 1) / ABT_CLK_NS;
  localparam logic [1:0] ABT_SPEED_STD = 2'h1;
  localparam logic [1:0] ABT_SPEED_FAST = 2'h2;
  // conversion lengths in main clock periods, indexed by time select
  localparam logic [7:0][7:0] ABT_CYC_STD = {8'h38, 8'h70, 8'hA8, 8'hE0, 8'h18, 8'h30, 8'h48, 8'h60};
  localparam logic [3:0][7:0] ABT_CYC_FAST = {8'h12, 8'h24, 8'h36, 8'h48};

  typedef struct packed {
    logic conv_enable;
    logic scan_select;
    logic [2:0] conv_time_sel;
    logic [1:0] conv_speed_sel;
    logic boost_ref_enable;
  } abt_mode_s;

  typedef struct packed {
    logic [1:0] trig_edge_sel;
    logic trig_source_sel;
    logic hw_trig_type;
    logic rsvd;
    logic [2:0] chan_sel;
  } abt_chan_s;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } abt_bus_req_s;

  typedef enum logic [2:0] {
    ABT_ST_IDLE = 3'b001,
    ABT_ST_WAIT = 3'b010,
    ABT_ST_CONV = 3'b100
  } abt_state_e;
endpackage : abt_pkg

// File: rtl/abt_tick_div.sv
// enable pulse generator for the converter main clock rate
// assumes a free-running system clock
`timescale 1ns/10ps
`default_nettype none
module abt_tick_div #(
  parameter int DIV = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [15:0] cnt;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt >= 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : abt_tick_div
`default_nettype wire

// File: rtl/abt_edge_det.sv
// synchroniser and selectable edge detector for the external trigger pin
// assumes the pin is asynchronous to the system clock
`timescale 1ns/10ps
`default_nettype none
module abt_edge_det (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic enable_i,
  input wire logic [1:0] edge_sel_i,
  output logic hit_o
);
  logic sync_a;
  logic sync_b;
  logic prev;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign hit_o = enable_i & ((edge_sel_i[1] & sync_b & ~prev) | (edge_sel_i[0] & ~sync_b & prev));

  pulse_single_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit_o |=> !hit_o) else $error("trigger hit longer than one cycle");
endmodule : abt_edge_det
`default_nettype wire

// File: sim/abt_trig_model.sv
// far-side model: external trigger pin and timer trigger event source
// assumes the bench calls its tasks hierarchically; both outputs idle low
`timescale 1ns/10ps
`default_nettype none
module abt_trig_model (
  input wire logic sys_clk_i,
  output logic ext_trig_pin_o,
  output logic timer_trig_event_o
);
  initial begin
    ext_trig_pin_o = 1'b0;
    timer_trig_event_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // one pin transition, launched on a clock edge
  task automatic pin_toggle();
    @(posedge sys_clk_i);
    ext_trig_pin_o <= ~ext_trig_pin_o;
  endtask : pin_toggle

  // single-cycle synchronous timer event
  task automatic timer_pulse();
    @(posedge sys_clk_i);
    timer_trig_event_o <= 1'b1;
    @(posedge sys_clk_i);
    timer_trig_event_o <= 1'b0;
  endtask : timer_pulse
endmodule : abt_trig_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the converter control block
// assumes abt_pkg, abt_ctrl and abt_trig_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import abt_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  abt_bus_req_s bus_req_i = '0;
  logic [7:0] bus_rdata_o;
  logic bus_wait_o;
  logic ext_trig_pin;
  logic timer_trig_event;
  logic boost_gen_on_o;
  logic ref_settled_o;
  logic conv_busy_o;
  logic conv_start_o;
  logic conv_done_irq_o;
  logic [1:0] analog_sel_o;
  logic [7:0] conv_cycles_o;
  logic cfg_ok_o;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_start = 0;
  int n_done = 0;
  int last_start = 0;
  int prev_start = 0;
  int last_done = 0;
  int wcyc = 0;
  logic [1:0] sel_q[$];

  always #10 sys_clk_i = ~sys_clk_i;

  abt_ctrl #(.MAIN_CLK_DIV(1)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .bus_wait_o(bus_wait_o), .ext_trig_pin_i(ext_trig_pin),
    .timer_trig_event_i(timer_trig_event), .boost_gen_on_o(boost_gen_on_o), .ref_settled_o(ref_settled_o),
    .conv_busy_o(conv_busy_o), .conv_start_o(conv_start_o), .conv_done_irq_o(conv_done_irq_o),
    .analog_sel_o(analog_sel_o), .conv_cycles_o(conv_cycles_o), .cfg_ok_o(cfg_ok_o));

  abt_trig_model u_trig (.sys_clk_i(sys_clk_i), .ext_trig_pin_o(ext_trig_pin),
    .timer_trig_event_o(timer_trig_event));

  ////////////////////////////////////////////////////////////////
  // pulse monitor
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (conv_start_o === 1'b1) begin
      n_start = n_start + 1;
      prev_start = last_start;
      last_start = cyc;
      sel_q.push_back(analog_sel_o);
    end
    if (conv_done_irq_o === 1'b1) begin
      n_done = n_done + 1;
      last_done = cyc;
    end
  end

  ////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_int(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_int

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : idle

  // write, then idle through the wait cycle
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge sys_clk_i);
    bus_req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d, wmask: m};
    @(posedge sys_clk_i);
    bus_req_i.wr <= 1'b0;
    #1;
    wcyc = cyc;
    chk_bit(bus_wait_o, (a == ABT_ADDR_MODE || a == ABT_ADDR_CHAN), "bus wait");
    idle(1);
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    bus_req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00, wmask: 8'h00};
    @(posedge sys_clk_i);
    bus_req_i.rd <= 1'b0;
    #1;
    chk8(bus_rdata_o, exp, "read data");
  endtask : bus_rd

  task automatic wait_start();
    int n0;
    n0 = n_start;
    for (int i = 0; i < 500 && n_start == n0; i++) idle(1);
    if (n_start == n0) begin
      failures++;
      $display("ERROR %0t no conversion start", $time);
      summarize();
    end
  endtask : wait_start

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    bus_rd(ABT_ADDR_MODE, 8'h00);
    bus_rd(ABT_ADDR_CHAN, 8'h00);
    bus_rd(16'hFF70, 8'h00);
    chk_bit(boost_gen_on_o, 1'b0, "gen after reset");
    chk_bit(conv_busy_o, 1'b0, "busy after reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs();
    bus_wr(ABT_ADDR_CHAN, 8'hFF, 8'hFF);
    bus_rd(ABT_ADDR_CHAN, 8'hF7);
    bus_wr(ABT_ADDR_CHAN, 8'h00, 8'h20);
    bus_rd(ABT_ADDR_CHAN, 8'hD7);
    bus_wr(ABT_ADDR_CHAN, 8'h02, 8'hFF);
    bus_rd(ABT_ADDR_CHAN, 8'h02);
    $display("register test done");
  endtask : t_regs

  task automatic t_boost();
    bus_wr(ABT_ADDR_MODE, 8'h01, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b1, "gen waiting");
    chk_bit(ref_settled_o, 1'b0, "early settle");
    chk_bit(conv_busy_o, 1'b0, "busy waiting");
    idle(ABT_SETTLE_CYC + 4);
    chk_bit(ref_settled_o, 1'b1, "settled");
    bus_wr(ABT_ADDR_MODE, 8'h00, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b0, "gen stopped");
    bus_wr(ABT_ADDR_MODE, 8'h9C, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b1, "gen auto on");
    chk_bit(conv_busy_o, 1'b1, "busy enable");
    bus_wr(ABT_ADDR_MODE, 8'h1C, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b0, "gen auto off");
    chk_bit(conv_busy_o, 1'b0, "busy stop");
    bus_wr(ABT_ADDR_MODE, 8'h9D, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b1, "gen on 11");
    bus_wr(ABT_ADDR_MODE, 8'h1D, 8'hFF);
    chk_bit(boost_gen_on_o, 1'b1, "gen stays");
    $display("boost test done");
  endtask : t_boost

  task automatic t_time();
    logic [7:0] std_t[8] = '{8'h60, 8'h48, 8'h30, 8'h18, 8'hE0, 8'hA8, 8'h70, 8'h38};
    logic [7:0] fast_t[4] = '{8'h48, 8'h36, 8'h24, 8'h12};
    logic [7:0] exp;
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 8; t++) begin
        bus_wr(ABT_ADDR_MODE, {2'b00, t[2:0], s[1:0], 1'b0}, 8'hFF);
        exp = (s == 1) ? std_t[t] : ((s == 2 && t < 4) ? fast_t[t[1:0]] : 8'h00);
        chk8(conv_cycles_o, exp, "conv cycles");
        chk_bit(cfg_ok_o, exp != 8'h00, "cfg ok");
      end
    end
    bus_wr(ABT_ADDR_MODE, 8'h1C, 8'hFF);
    bus_wr(ABT_ADDR_CHAN, 8'h04, 8'hFF);
    chk_bit(cfg_ok_o, 1'b0, "bad channel");
    bus_wr(ABT_ADDR_CHAN, 8'h02, 8'hFF);
    chk_bit(cfg_ok_o, 1'b1, "good channel");
    $display("conversion time test done");
  endtask : t_time

  task automatic t_sw();
    int n0;
    bus_wr(ABT_ADDR_MODE, 8'h1D, 8'hFF);
    idle(ABT_SETTLE_CYC + 2);
    bus_wr(ABT_ADDR_MODE, 8'h9D, 8'hFF);
    chk_int(last_start, wcyc + 1, "sw start");
    idle(60);
    chk_int(last_start - prev_start, 18, "period");
    chk_int(last_done, last_start, "back to back");
    chk8({6'h00, sel_q[$]}, 8'h02, "select chan");
    wait_start();
    idle(5);
    n0 = n_done;
    bus_wr(ABT_ADDR_PFAIL_MODE, 8'h00, 8'hFF);
    idle(12);
    chk_int(n_done, n0, "aborted");
    chk_int(last_start, wcyc + 1, "restart");
    idle(8);
    chk_int(last_done, wcyc + 19, "restart length");
    bus_wr(ABT_ADDR_MODE, 8'h1D, 8'hFF);
    chk_bit(conv_busy_o, 1'b0, "stopped");
    $display("software trigger test done");
  endtask : t_sw

  task automatic t_scan();
    sel_q.delete();
    bus_wr(ABT_ADDR_MODE, 8'hDD, 8'hFF);
    idle(4 * 18 + 4);
    for (int i = 0; i < 4; i++) chk8({6'h00, sel_q[i]}, 8'(i % 3), "scan chan");
    bus_wr(ABT_ADDR_MODE, 8'h1D, 8'hFF);
    $display("scan test done");
  endtask : t_scan

  task automatic t_hw();
    logic [7:0] cfg[5] = '{8'h20, 8'h60, 8'hA0, 8'hE0, 8'hF0};
    int exp[5] = '{0, 1, 1, 2, 1};
    int n0;
    for (int k = 0; k < 5; k++) begin
      bus_wr(ABT_ADDR_CHAN, cfg[k], 8'hFF);
      n0 = n_start;
      bus_wr(ABT_ADDR_MODE, 8'h9D, 8'hFF);
      idle(5);
      u_trig.pin_toggle();
      idle(30);
      u_trig.pin_toggle();
      idle(30);
      u_trig.timer_pulse();
      idle(30);
      chk_int(n_start - n0, exp[k], "hw starts");
      bus_wr(ABT_ADDR_MODE, 8'h1D, 8'hFF);
    end
    $display("hardware trigger test done");
  endtask : t_hw

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_boost();
    t_time();
    t_sw();
    t_scan();
    t_hw();
    summarize();
  end
endmodule : testbench
`default_nettype wire
